// File: rtl/psm_pkg.sv
// Constants shared by the port S / port M pin-control block.
package psm_pkg;
  // Register indices; the bus byte address is four times the index.
  localparam logic [5:0] IDX_S_PULL_EN = 6'h0C;
  localparam logic [5:0] IDX_S_PULL_POL = 6'h0D;
  localparam logic [5:0] IDX_S_OD_SEL = 6'h0E;
  localparam logic [5:0] IDX_M_DATA = 6'h10;
  localparam logic [5:0] IDX_M_PIN_LVL = 6'h11;
  localparam logic [5:0] IDX_M_DIR = 6'h12;
  localparam logic [5:0] IDX_M_DRIVE = 6'h13;
  // Implemented widths.
  localparam int S_PINS = 4;
  localparam int M_PINS = 6;
  // Field positions on port M.
  localparam int M_RX_BIT = 0;
  localparam int M_TX_BIT = 1;
  localparam int M_SPI_LO = 2;
  localparam int M_SPI_HI = 5;
  // Reset values.
  localparam logic [3:0] RST_S_PULL_EN = 4'hF;
  localparam logic [3:0] RST_S_PULL_POL = 4'h0;
  localparam logic [3:0] RST_S_OD_SEL = 4'h0;
  localparam logic [5:0] RST_M_DATA = 6'h00;
  localparam logic [5:0] RST_M_DIR = 6'h00;
  localparam logic [5:0] RST_M_DRIVE = 6'h00;
  // Pin synchroniser depth in bus cycles.
  localparam int SYNC_STAGES = 2;
  // AHB transfer type bit that marks NONSEQ or SEQ.
  localparam int HTRANS_ACTIVE = 1;
endpackage

// File: rtl/psm_pin_ctrl.sv
// Port S pull / open-drain control and port M data, direction and drive, on AHB-Lite.
`timescale 1ns/1ns
//
// Summary of operation
// (RULE_01) Port S pull enable acts on inputs and open-drain outputs, not push-pull.
// (RULE_02) After reset every port S pull is enabled with pull-up polarity.
// (RULE_03) Polarity 0 with pull enabled gives pull-up on inputs and open-drain outputs.
// (RULE_04) Polarity 1 with pull enabled gives pull-down, only on inputs.
// (RULE_05) Open-drain bit drives low only; clear gives push-pull; inputs unaffected.
// (RULE_06) Port M data reads latch for output pins, live pin level otherwise.
// (RULE_07) Port M pins five to two follow SPI status signals, not port settings.
// (RULE_08) Port M pin level register always returns pin levels, outputs included.
// (RULE_09) Writes to the port M pin level register are ignored.
// (RULE_10) Port M direction bit 0 gives input, 1 gives output, unless overridden.
// (RULE_11) An enabled SPI or CAN controller sets the direction of its pins.
// (RULE_12) Enabled transmit channel forces output; enabled receive channel forces input.
// (RULE_13) A disabled channel returns pin direction to the direction register.
// (RULE_14) Pin reads may lag a direction change by up to two bus cycles.
// (RULE_15) Drive bit 1 gives reduced drive on outputs; ignored on inputs.
// (RULE_16) Registers are 8-bit locations; unimplemented bits read zero, ignore writes.
module psm_pin_ctrl (
  input wire logic clock,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port S: direction and output value come from the port S data logic.
  input wire logic [3:0] s_dir,
  input wire logic [3:0] s_out,
  output logic [3:0] s_pin_o,
  output logic [3:0] s_pin_oe,
  output logic [3:0] s_pull_up,
  output logic [3:0] s_pull_dn,
  // Port M pins.
  input wire logic [5:0] m_pin_i,
  output logic [5:0] m_pin_o,
  output logic [5:0] m_pin_oe,
  output logic [5:0] m_reduced,
  output logic [5:0] m_pin_level,
  // Peripheral overrides.
  input wire logic spi_en,
  input wire logic [3:0] spi_dir,
  input wire logic [3:0] spi_out,
  input wire logic sci_tx_en,
  input wire logic sci_rx_en,
  input wire logic sci_tx_d,
  input wire logic can_tx_en,
  input wire logic can_rx_en,
  input wire logic can_tx_d
);

  // ****************************************
  // Bus address phase
  // ****************************************
  logic [5:0] addr_idx_r;
  logic addr_ok_r;
  logic wr_pend_r;
  logic rd_now;
  logic acc_now;
  logic addr_in_map;

  assign acc_now = hsel & htrans[psm_pkg::HTRANS_ACTIVE] & hready;
  assign rd_now = acc_now & ~hwrite;
  assign addr_in_map = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      addr_idx_r <= 6'h00;
      addr_ok_r <= 1'b0;
      wr_pend_r <= 1'b0;
    end else begin
      if (hready) begin
        wr_pend_r <= acc_now & hwrite;
        addr_idx_r <= haddr[7:2];
        addr_ok_r <= addr_in_map;
      end
    end
  end

  // Zero-wait slave: every transfer completes in one data phase with OKAY.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] s_pull_en_r;
  logic [3:0] s_pull_pol_r;
  logic [3:0] s_od_sel_r;
  logic [5:0] m_data_r;
  logic [5:0] m_dir_r;
  logic [5:0] m_drive_r;
  logic wr_ok;

  assign wr_ok = wr_pend_r & addr_ok_r;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_pull_en_r <= psm_pkg::RST_S_PULL_EN; // RULE_02
      s_pull_pol_r <= psm_pkg::RST_S_PULL_POL; // RULE_02
      s_od_sel_r <= psm_pkg::RST_S_OD_SEL;
    end else if (wr_ok) begin
      // Only the implemented low bits are stored; the rest are dropped.
      case (addr_idx_r)
        psm_pkg::IDX_S_PULL_EN: s_pull_en_r <= hwdata[3:0]; // RULE_16
        psm_pkg::IDX_S_PULL_POL: s_pull_pol_r <= hwdata[3:0];
        psm_pkg::IDX_S_OD_SEL: s_od_sel_r <= hwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      m_data_r <= psm_pkg::RST_M_DATA;
      m_dir_r <= psm_pkg::RST_M_DIR;
      m_drive_r <= psm_pkg::RST_M_DRIVE;
    end else if (wr_ok) begin
      // The data latch takes writes whatever the pin direction.
      case (addr_idx_r)
        psm_pkg::IDX_M_DATA: m_data_r <= hwdata[5:0]; // RULE_06
        psm_pkg::IDX_M_DIR: m_dir_r <= hwdata[5:0];
        psm_pkg::IDX_M_DRIVE: m_drive_r <= hwdata[5:0];
        // The pin level location has no storage, so a write there is lost.
        psm_pkg::IDX_M_PIN_LVL: begin // RULE_09
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Port M pin synchroniser
  // ****************************************
  logic [5:0] m_sync1_r;

  // Two stages, hence the up-to-two-cycle lag of pin reads.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      m_sync1_r <= 6'h00;
      m_pin_level <= 6'h00;
    end else begin
      m_sync1_r <= m_pin_i; // RULE_14
      m_pin_level <= m_sync1_r;
    end
  end

  // ****************************************
  // Port M direction and output selection
  // ****************************************
  logic [5:0] m_dir_eff;
  logic [5:0] m_out_eff;
  logic rx_on;
  logic tx_on;

  assign rx_on = sci_rx_en | can_rx_en;
  assign tx_on = sci_tx_en | can_tx_en;

  always_comb begin
    m_dir_eff = m_dir_r; // RULE_10 RULE_13
    m_out_eff = m_data_r;
    if (rx_on) begin
      m_dir_eff[psm_pkg::M_RX_BIT] = 1'b0; // RULE_12
    end
    if (tx_on) begin
      m_dir_eff[psm_pkg::M_TX_BIT] = 1'b1; // RULE_11 RULE_12
      m_out_eff[psm_pkg::M_TX_BIT] = can_tx_en ? can_tx_d : sci_tx_d;
    end
    if (spi_en) begin
      m_dir_eff[psm_pkg::M_SPI_HI:psm_pkg::M_SPI_LO] = spi_dir; // RULE_07 RULE_11
      m_out_eff[psm_pkg::M_SPI_HI:psm_pkg::M_SPI_LO] = spi_out; // RULE_07
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      m_pin_oe <= 6'h00;
      m_pin_o <= 6'h00;
      m_reduced <= 6'h00;
    end else begin
      m_pin_oe <= m_dir_eff; // RULE_10
      m_pin_o <= m_out_eff;
      m_reduced <= m_drive_r & m_dir_eff; // RULE_15
    end
  end

  // ****************************************
  // Port S pad control
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_pin_o <= 4'h0;
      s_pin_oe <= 4'h0;
      s_pull_up <= 4'h0;
      s_pull_dn <= 4'h0;
    end else begin
      // Open-drain leaves a high undriven so the pull or the bus wire sets it.
      s_pin_o <= s_out & ~s_od_sel_r; // RULE_05
      s_pin_oe <= s_dir & ~(s_od_sel_r & s_out); // RULE_05
      s_pull_up <= s_pull_en_r & ~s_pull_pol_r & (~s_dir | s_od_sel_r); // RULE_01 RULE_03
      s_pull_dn <= s_pull_en_r & s_pull_pol_r & ~s_dir; // RULE_01 RULE_04
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (addr_in_map) begin
      case (haddr[7:2])
        psm_pkg::IDX_S_PULL_EN: rd_mux = {4'h0, s_pull_en_r}; // RULE_16
        psm_pkg::IDX_S_PULL_POL: rd_mux = {4'h0, s_pull_pol_r};
        psm_pkg::IDX_S_OD_SEL: rd_mux = {4'h0, s_od_sel_r};
        psm_pkg::IDX_M_DATA: begin
          rd_mux = {2'h0, (m_data_r & m_dir_eff) | (m_pin_level & ~m_dir_eff)}; // RULE_06
        end
        psm_pkg::IDX_M_PIN_LVL: rd_mux = {2'h0, m_pin_level}; // RULE_08
        psm_pkg::IDX_M_DIR: rd_mux = {2'h0, m_dir_r};
        psm_pkg::IDX_M_DRIVE: rd_mux = {2'h0, m_drive_r};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      hrdata <= {24'h000000, rd_mux};
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  chk_pull_reset: assert property ( // RULE_02
    $past(!rst_b) |-> (s_pull_en_r == 4'hF) && (s_pull_pol_r == 4'h0))
    else $error("port S pulls not enabled as pull-up after reset");

  chk_pull_up_sel: assert property ( // RULE_03
    (s_pull_en_r[0] && !s_pull_pol_r[0] && (!s_dir[0] || s_od_sel_r[0])) |=> s_pull_up[0])
    else $error("pull-up missing on port S pin 0");

  chk_pull_dn_input: assert property ( // RULE_04
    s_pull_dn[1] |-> $past(!s_dir[1] && s_pull_pol_r[1] && s_pull_en_r[1]))
    else $error("pull-down active on a non-input port S pin");

  chk_push_pull_nopull: assert property ( // RULE_01
    (s_dir[2] && !s_od_sel_r[2]) |=> !s_pull_up[2] && !s_pull_dn[2])
    else $error("pull active on a push-pull port S output");

  chk_open_drain_low: assert property ( // RULE_05
    (s_dir[3] && s_od_sel_r[3] && s_out[3]) |=> !s_pin_oe[3])
    else $error("open-drain pin drove a high level");

  chk_pin_sync_lag: assert property ( // RULE_14
    m_pin_level == $past(m_pin_i, 2) or $past(!rst_b, 2))
    else $error("pin levels not two cycles behind the pads");

  chk_pin_lvl_read: assert property ( // RULE_08
    (rd_now && addr_in_map && haddr[7:2] == psm_pkg::IDX_M_PIN_LVL)
      |=> hrdata == {26'h0000000, $past(m_pin_level)})
    else $error("pin level read differs from synchronised pins");

  chk_tx_forces_out: assert property ( // RULE_12
    tx_on |=> m_pin_oe[1])
    else $error("transmit channel did not force output");

  chk_rx_forces_in: assert property ( // RULE_12
    rx_on |=> !m_pin_oe[0])
    else $error("receive channel did not force input");

  chk_spi_dir: assert property ( // RULE_11
    spi_en |=> m_pin_oe[5:2] == $past(spi_dir))
    else $error("SPI did not control port M direction");

  chk_dir_return: assert property ( // RULE_13
    (!spi_en && !rx_on && !tx_on) |=> m_pin_oe == $past(m_dir_r))
    else $error("direction register not in control with channels off");

  chk_reduced_out: assert property ( // RULE_15
    (m_reduced & ~m_pin_oe) == 6'h00)
    else $error("reduced drive on an input pin");

  // The ready flop still shows its reset value at the first edge out of reset.
  chk_upper_zero: assert property ( // RULE_16
    hrdata[31:8] == 24'h000000 && !hresp && (hreadyout || $past(!rst_b)))
    else $error("read data upper bits or response wrong");

  // Output pins read back their latch, input pins their synchronised level.
  chk_data_read: assert property ( // RULE_06
    (rd_now && addr_in_map && haddr[7:2] == psm_pkg::IDX_M_DATA)
      |=> hrdata[5:0] == $past((m_data_r & m_dir_eff) | (m_pin_level & ~m_dir_eff)))
    else $error("port M data read mixes latch and pins wrongly");

  chk_lvl_wr_ignored: assert property ( // RULE_09
    (wr_ok && addr_idx_r == psm_pkg::IDX_M_PIN_LVL)
      |=> $stable(m_data_r) && $stable(m_dir_r) && $stable(m_drive_r))
    else $error("write to pin level location changed a register");

  chk_od_out_low: assert property ( // RULE_05
    s_od_sel_r[1] |=> !s_pin_o[1])
    else $error("open-drain pin presented a high output value");

  chk_reduced_sel: assert property ( // RULE_15
    (m_drive_r[0] && m_dir_eff[0]) |=> m_reduced[0])
    else $error("reduced drive missing on an output pin");

  // Covers for the main traffic: writes, overrides and open-drain use.
  cov_rx_input: cover property (rx_on ##1 !m_pin_oe[0]);

  cov_write_then_read: cover property (wr_ok ##1 rd_now);
  cov_spi_override: cover property (spi_en && m_dir_r[5:2] != spi_dir);
  cov_open_drain: cover property (s_od_sel_r[0] && s_dir[0] && s_pull_up[0]);
  cov_can_tx: cover property (can_tx_en ##1 m_pin_oe[1]);

endmodule

// File: test/psm_pad_model.sv
// Pad-side model of the port M pins: external drivers and shorts.
`timescale 1ns/1ns
module psm_pad_model (
  input wire logic [5:0] m_pin_o,
  input wire logic [5:0] m_pin_oe,
  input wire logic [5:0] ext_lvl,
  input wire logic [5:0] short_msk,
  output logic [5:0] m_pin_i
);
  // ****************************************
  // Pad level
  // ****************************************
  // A shorted pin shows the external level even while driven, so an overload is visible.
  // An undriven pin never keeps its last value; it shows whatever the board puts on it.
  assign m_pin_i = (m_pin_oe & ~short_msk & m_pin_o) | ((~m_pin_oe | short_msk) & ext_lvl);
endmodule

// File: test/tb_top.sv
// Self-checking bench for the port S / port M pin-control block.
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic rd_pend = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] seed = 32'hB02C74A9;
  logic [3:0] s_dir = 4'h0, s_out = 4'h0, spi_dir = 4'h0, spi_out = 4'h0;
  logic [5:0] ext_lvl = 6'h2A, short_msk = 6'h0;
  logic spi_en = 1'h0, sci_tx_en = 1'h0, sci_rx_en = 1'h0, can_tx_en = 1'h0, can_rx_en = 1'h0;
  logic sci_tx_d = 1'h0, can_tx_d = 1'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [3:0] s_pin_o, s_pin_oe, s_pull_up, s_pull_dn;
  logic [5:0] m_pin_i, m_pin_o, m_pin_oe, m_reduced, m_pin_level;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;

  psm_pin_ctrl dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .s_dir, .s_out, .s_pin_o, .s_pin_oe,
    .s_pull_up, .s_pull_dn, .m_pin_i, .m_pin_o, .m_pin_oe, .m_reduced, .m_pin_level, .spi_en,
    .spi_dir, .spi_out, .sci_tx_en, .sci_rx_en, .sci_tx_d, .can_tx_en, .can_rx_en, .can_tx_d);
  psm_pad_model pads (.m_pin_o, .m_pin_oe, .ext_lvl, .short_msk, .m_pin_i);

  initial forever #25 clock = ~clock;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for hready sampled high; a hang ends the run.
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    hwait();
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'h0, 32'h0);
  endtask

  // ****************************************
  // Read monitor
  // ****************************************
  always @(posedge clock) begin
    if (rd_pend && hreadyout === 1'h1) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("read data", exp_q.pop_front(), hrdata);
    end
    if (hreadyout === 1'h1) rd_pend <= hsel && htrans[1] && !hwrite;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic [5:0] oe, po, pv;
    repeat (8) @(posedge clock);
    rst_b <= 1'h1;
    hwait();
    rd(32'h30, 32'hF);
    rd(32'h34, 32'h0);
    rd(32'h38, 32'h0);
    rd(32'h48, 32'h0);
    rd(32'h4C, 32'h0);
    rd(32'h50, 32'h0);
    @(negedge clock);
    chk("pull up", 32'hF, s_pull_up);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      wr(32'h30, r);
      wr(32'h34, r >> 4);
      wr(32'h38, r >> 8);
      s_dir <= r[15:12];
      s_out <= r[19:16];
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("pull up", r[3:0] & ~r[7:4] & (~s_dir | r[11:8]), s_pull_up);
      chk("pull down", r[3:0] & r[7:4] & ~s_dir, s_pull_dn);
      chk("pad oe", s_dir & ~(r[11:8] & s_out), s_pin_oe);
      chk("pad out", s_dir & s_out & ~r[11:8], s_pin_o & s_dir);
      rd(32'h34, r[7:4]);
      rd(32'h38, r[11:8]);
    end
    $display("test port s done");
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      {spi_dir, spi_out, sci_tx_d, can_tx_d, ext_lvl} <= r[15:0];
      short_msk <= r[21:16] & r[27:22];
      {spi_en, sci_tx_en, sci_rx_en, can_tx_en, can_rx_en} <= (i > 8) ? 5'h0 : r[31:27];
      r = rnd();
      wr(32'h40, r);
      wr(32'h48, r >> 8);
      wr(32'h4C, r >> 16);
      wr(32'h44, ~r);
      repeat (3) @(posedge clock);
      @(negedge clock);
      oe = r[13:8];
      po = r[5:0];
      if (spi_en) begin
        oe[5:2] = spi_dir;
        po[5:2] = spi_out;
      end
      if (sci_tx_en | can_tx_en) begin
        oe[1] = 1'h1;
        po[1] = can_tx_en ? can_tx_d : sci_tx_d;
      end
      if (sci_rx_en | can_rx_en) oe[0] = 1'h0;
      pv = (oe & ~short_msk & po) | ((~oe | short_msk) & ext_lvl);
      chk("pin oe", oe, m_pin_oe);
      chk("pin out", po & oe, m_pin_o & m_pin_oe);
      chk("reduced", r[21:16] & oe, m_reduced);
      rd(32'h40, (oe & r[5:0]) | (~oe & pv));
      rd(32'h44, pv);
      rd(32'h48, r[13:8]);
      rd(32'h4C, r[21:16]);
    end
    $display("test port m done");
    @(negedge clock);
    chk("reads left", 32'h0, exp_q.size());
    summarize();
  end
endmodule
